// >>> include/ssst_cfg_if.sv
// configuration carried from the register bank to the sensor-data path
`timescale 1ns/10ps
interface ssst_cfg_if;
    logic [1:0][1:0] type_sel;
    logic [3:0] st_code;
    logic path_en;

    modport cfg (output type_sel, output st_code, output path_en);
    modport path (input type_sel, input st_code, input path_en);
endinterface : ssst_cfg_if

// >>> include/ssst_pkg.sv
// constants and types shared by the output-select and self-test register bank
package ssst_pkg;

    // ==========================================================
    // register map
    localparam logic [7:0] SSST_ADDR_SLOT_TYPE = 8'h42;
    localparam logic [7:0] SSST_ADDR_INT_PIN = 8'h43;
    localparam logic [7:0] SSST_ADDR_SELFTEST = 8'h44;
    localparam logic [7:0] SSST_RST_SLOT_TYPE = 8'h00;
    localparam logic [7:0] SSST_RST_INT_PIN = 8'h00;
    localparam logic [7:0] SSST_RST_SELFTEST = 8'h00;
    localparam logic [7:0] SSST_RDATA_UNMAPPED = 8'h00;

    // ==========================================================
    // field positions
    localparam int SSST_FIRST_TYPE_LSB = 5;
    localparam int SSST_SECOND_TYPE_LSB = 2;
    localparam int SSST_INT_MODE_BIT = 2;
    localparam int SSST_ST_LSB = 4;

    // ==========================================================
    // encodings
    localparam logic [1:0] SSST_TYPE_PRESSURE = 2'h1;
    localparam logic [1:0] SSST_TYPE_TEMP = 2'h3;
    localparam logic [3:0] SSST_ST_NORMAL = 4'h0;
    localparam logic [3:0] SSST_ST_CM_VERIFY = 4'h1;
    localparam logic [1:0] SSST_ST_GRP_PATTERN = 2'h1;
    localparam logic [1:0] SSST_ST_GRP_DST = 2'h3;
    localparam logic [15:0] SSST_PAT0 = 16'h0000;
    localparam logic [15:0] SSST_PAT1 = 16'hAAAA;
    localparam logic [15:0] SSST_PAT2 = 16'h5555;
    localparam logic [15:0] SSST_PAT3 = 16'hFFFF;

    typedef enum logic [1:0]
    {
        SSST_RUN = 2'b01,
        SSST_INIT = 2'b10
    } ssst_state_t;

    function automatic logic [15:0] ssst_pattern(input logic [1:0] idx);
        logic [15:0] pat;
        pat = SSST_PAT0;
        case (idx)
            2'h1: pat = SSST_PAT1;
            2'h2: pat = SSST_PAT2;
            2'h3: pat = SSST_PAT3;
            default: pat = SSST_PAT0;
        endcase
        return pat;
    endfunction : ssst_pattern

endpackage : ssst_pkg

// >>> verification/ssst_host_model.sv
// host-side register bus model for the output-select and self-test bank
`timescale 1ns/10ps
module ssst_host_model
    import ssst_pkg::*;
(
    input wire logic i_mclk,
    input wire logic [7:0] i_reg_rdata,
    output logic [7:0] o_reg_addr,
    output logic [7:0] o_reg_wdata,
    output logic o_reg_wr,
    output logic o_reg_rd
);
    initial
    begin
        o_reg_addr = 8'h00;
        o_reg_wdata = 8'h00;
        o_reg_wr = 1'b0;
        o_reg_rd = 1'b0;
    end

    // ==========================================================
    // bus cycles
    function automatic logic st_legal(input logic [7:0] d);
        return (d[3:0] == 4'h0) && (d[7:5] != 3'h1) && (d[7:6] != 2'h2);
    endfunction : st_legal

    // reserved self-test codes are dropped, never put on the bus
    task automatic write_reg(input logic [7:0] addr, input logic [7:0] data);
        if ((addr == SSST_ADDR_SELFTEST) && !st_legal(data))
        begin
            return;
        end
        @(posedge i_mclk);
        o_reg_addr <= addr;
        o_reg_wdata <= data;
        o_reg_wr <= 1'b1;
        @(posedge i_mclk);
        o_reg_wr <= 1'b0;
        // idle bus carries no stale values
        o_reg_addr <= ~addr;
        o_reg_wdata <= ~data;
    endtask : write_reg

    task automatic read_reg(input logic [7:0] addr, output logic [7:0] data);
        @(posedge i_mclk);
        o_reg_addr <= addr;
        o_reg_rd <= 1'b1;
        @(posedge i_mclk);
        o_reg_rd <= 1'b0;
        o_reg_addr <= ~addr;
        #1;
        data = i_reg_rdata;
    endtask : read_reg
endmodule : ssst_host_model

// >>> verification/tb.sv
// self-checking bench for the output-select and self-test register bank
`timescale 1ns/10ps
module tb
    import ssst_pkg::*;
;
    logic i_mclk, i_reset_n, reg_wr, reg_rd, sample_stb, dst_valid, init_done, int_event;
    logic [7:0] reg_addr, reg_wdata, reg_rdata, sig, rd;
    logic [15:0] pressure, temperature, dst_result, slot0, slot1;
    logic [1:0] type0, type1, dst_index;
    logic [3:0] st_sel;
    logic cm_en, inhibit, dst_run, restart, data_valid, pin_o, pin_oe, pull_up, pull_down;
    logic int_line;
    logic [15:0] pats [4] = '{16'h0000, 16'hAAAA, 16'h5555, 16'hFFFF};
    int num_errors = 0;
    int comparisons = 0;

    // open-drain wire: driven level, else the selected pull
    assign int_line = pin_oe ? pin_o : pull_up;

    ssst_host_model host (.i_mclk(i_mclk), .i_reg_rdata(reg_rdata), .o_reg_addr(reg_addr),
        .o_reg_wdata(reg_wdata), .o_reg_wr(reg_wr), .o_reg_rd(reg_rd));

    ssst_top dut (.i_mclk(i_mclk), .i_reset_n(i_reset_n), .i_reg_addr(reg_addr),
        .i_reg_wdata(reg_wdata), .i_reg_wr(reg_wr), .i_reg_rd(reg_rd), .o_reg_rdata(reg_rdata),
        .i_sample_stb(sample_stb), .i_pressure(pressure), .i_temperature(temperature),
        .i_dst_valid(dst_valid), .i_dst_result(dst_result), .i_dsp_init_done(init_done),
        .i_int_event(int_event), .o_first_slot_data(slot0), .o_second_slot_data(slot1),
        .o_first_slot_type_sel(type0), .o_second_slot_type_sel(type1),
        .o_selftest_select(st_sel), .o_cm_verify_en(cm_en), .o_dsp_inhibit(inhibit),
        .o_dst_run(dst_run), .o_dst_index(dst_index), .o_dsp_restart(restart),
        .o_data_valid(data_valid), .o_array_sig(sig), .o_int_pin_o(pin_o),
        .o_int_pin_oe(pin_oe), .o_int_pull_up_en(pull_up), .o_int_pull_down_en(pull_down));

    initial
    begin
        i_mclk = 1'b0;
        forever #5 i_mclk = ~i_mclk;
    end

    // ==========================================================
    // compare and stimulus tasks
    task automatic chk16(input logic [15:0] got, input logic [15:0] exp, input string what);
        comparisons++;
        if (got !== exp)
        begin
            num_errors++;
            $display("Error at %0t: %s got %h expected %h", $time, what, got, exp);
        end
    endtask : chk16

    task automatic chk8(input logic [7:0] got, input logic [7:0] exp, input string what);
        chk16({8'h00, got}, {8'h00, exp}, what);
    endtask : chk8

    task automatic chk1(input logic got, input logic exp, input string what);
        chk16({15'h0000, got}, {15'h0000, exp}, what);
    endtask : chk1

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        host.write_reg(a, d);
        #1;
    endtask : wr

    task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp, input string what);
        host.read_reg(a, rd);
        chk8(rd, exp, what);
    endtask : rd_chk

    task automatic sample(input logic [15:0] p, input logic [15:0] t);
        @(posedge i_mclk);
        sample_stb <= 1'b1;
        pressure <= p;
        temperature <= t;
        @(posedge i_mclk);
        sample_stb <= 1'b0;
        pressure <= ~p;
        temperature <= ~t;
        #1;
    endtask : sample

    // restart, refused sample while re-initialising, then release
    task automatic set_types(input logic [1:0] t0, input logic [1:0] t1);
        logic [15:0] prev0;
        logic [15:0] prev1;
        prev0 = slot0;
        prev1 = slot1;
        wr(SSST_ADDR_SLOT_TYPE, {1'b0, t0, 1'b0, t1, 2'b00});
        chk1(restart, 1'b1, "restart pulse");
        chk1(data_valid, 1'b0, "valid in init");
        chk8({type0, type1, 4'h0}, {t0, t1, 4'h0}, "type select");
        sample(16'h0BAD, 16'h0BAD);
        chk16(slot0, prev0, "first slot in init");
        chk16(slot1, prev1, "second slot in init");
        @(posedge i_mclk);
        init_done <= 1'b1;
        @(posedge i_mclk);
        init_done <= 1'b0;
        #1;
        chk1(data_valid, 1'b1, "valid after init");
        chk1(restart, 1'b0, "restart one cycle");
    endtask : set_types

    task automatic end_sim();
        $display("comparisons %0d mismatches %0d", comparisons, num_errors);
        if ((num_errors == 0) && (comparisons > 0))
        begin
            $display("== PASSED ==");
        end
        else
        begin
            $display("== FAILED ==");
        end
        $finish;
    endtask : end_sim

    initial
    begin
        repeat (5000) @(posedge i_mclk);
        num_errors++;
        $display("Error at %0t: run timed out", $time);
        end_sim();
    end

    // ==========================================================
    // main sequence
    initial
    begin
        {i_reset_n, sample_stb, dst_valid, init_done, int_event} = 5'h00;
        {pressure, temperature, dst_result} = 48'h0;
        repeat (2) @(posedge i_mclk);
        i_reset_n <= 1'b1;
        #1;
        chk1(pull_down, 1'b1, "reset pull-down");
        chk1(int_line, 1'b0, "reset idle line");
        chk1(pin_oe, 1'b0, "reset pin released");
        chk1(data_valid, 1'b1, "reset valid");
        rd_chk(SSST_ADDR_SLOT_TYPE, 8'h00, "42h reset");
        rd_chk(SSST_ADDR_INT_PIN, 8'h00, "43h reset");
        rd_chk(SSST_ADDR_SELFTEST, 8'h00, "44h reset");
        rd_chk(8'h50, 8'h00, "unmapped read");
        $display("test reset done");

        set_types(2'h1, 2'h3);
        sample(16'h1234, 16'hABCD);
        chk16(slot0, 16'h1234, "first slot pressure");
        chk16(slot1, 16'hABCD, "second slot temperature");
        set_types(2'h3, 2'h1);
        sample(16'h0F0F, 16'h7E81);
        chk16(slot0, 16'h7E81, "first slot temperature");
        chk16(slot1, 16'h0F0F, "second slot pressure");
        rd_chk(SSST_ADDR_SLOT_TYPE, 8'h64, "42h readback");
        $display("test slot types done");

        for (int m = 0; m < 2; m++)
        begin
            wr(SSST_ADDR_INT_PIN, {5'h00, 1'(m), 2'b00});
            chk1(pull_up, 1'(m), "pull-up select");
            chk1(pull_down, ~1'(m), "pull-down select");
            chk1(int_line, 1'(m), "idle line");
            @(posedge i_mclk);
            int_event <= 1'b1;
            #1;
            chk8(sig, 8'h64 ^ {5'h00, 1'(m), 2'b00}, "signature");
            @(posedge i_mclk);
            int_event <= 1'b0;
            #1;
            chk1(pin_oe, 1'b1, "pin driven");
            chk1(int_line, ~1'(m), "active line");
            @(posedge i_mclk);
            #1;
            chk1(pin_oe, 1'b0, "pin released");
        end
        rd_chk(SSST_ADDR_INT_PIN, 8'h04, "43h readback");
        $display("test int pin done");

        for (int k = 0; k < 4; k++)
        begin
            wr(SSST_ADDR_SELFTEST, {2'b01, 2'(k), 4'h0});
            chk1(inhibit, 1'b1, "dsp inhibit");
            sample(16'h3C3C, 16'h3C3C);
            chk16(slot0, pats[k], "first slot pattern");
            chk16(slot1, pats[k], "second slot pattern");
            @(posedge i_mclk);
            #1;
            chk8(sig, 8'h60, "signature ignores self-test");
        end
        $display("test patterns done");

        for (int k = 0; k < 4; k++)
        begin
            wr(SSST_ADDR_SELFTEST, {2'b11, 2'(k), 4'h0});
            chk8({dst_run, inhibit, dst_index, st_sel}, {2'b10, 2'(k), 2'b11, 2'(k)}, "dst");
            @(posedge i_mclk);
            dst_valid <= 1'b1;
            dst_result <= 16'hC0DE + 16'(k);
            @(posedge i_mclk);
            dst_valid <= 1'b0;
            sample(16'h1111, 16'h2222);
            chk16(slot0, 16'hC0DE + 16'(k), "first slot dst");
            chk16(slot1, 16'hC0DE + 16'(k), "second slot dst");
        end
        $display("test digital self-test done");

        for (int k = 0; k < 2; k++)
        begin
            wr(SSST_ADDR_SELFTEST, {3'b000, 1'(k), 4'h0});
            chk8({cm_en, inhibit, dst_run, 1'b0, st_sel}, {1'(k), 3'b000, 4'(k)}, "normal");
            sample(16'h5A00 + 16'(k), 16'h00A5);
            chk16(slot1, 16'h5A00 + 16'(k), "pressure slot");
            chk16(slot0, 16'h00A5, "temperature slot");
        end
        host.write_reg(SSST_ADDR_SELFTEST, 8'h20);
        rd_chk(SSST_ADDR_SELFTEST, 8'h10, "44h after reserved");
        $display("test normal codes done");
        end_sim();
    end
endmodule : tb

// >>> verilog/ssst_slot_path.sv
// sensor-data slot registers with type select, fixed patterns and self-test results
`timescale 1ns/10ps
module ssst_slot_path
    import ssst_pkg::*;
(
    input wire logic i_mclk,
    input wire logic i_reset_n,
    ssst_cfg_if.path cfg,
    input wire logic i_sample_stb,
    input wire logic [15:0] i_pressure,
    input wire logic [15:0] i_temperature,
    input wire logic i_dst_valid,
    input wire logic [15:0] i_dst_result,
    output logic [1:0][15:0] o_slot_data
);

    // ==========================================================
    // one data register per slot
    for (genvar g = 0; g < 2; g++)
    begin : g_slot
        logic [15:0] data_r;
        logic [15:0] data_nxt;
        logic [1:0] grp;

        assign grp = cfg.st_code[3:2];

        always_comb
        begin
            data_nxt = data_r;
            if (grp == SSST_ST_GRP_PATTERN)
            begin
                // dsp writes blocked, fixed pattern shown
                data_nxt = ssst_pattern(cfg.st_code[1:0]);
            end
            else if (grp == SSST_ST_GRP_DST)
            begin
                if (i_dst_valid)
                begin
                    data_nxt = i_dst_result;
                end
            end
            else if (cfg.path_en && i_sample_stb)
            begin
                // reserved codes behave as normal operation
                if (cfg.type_sel[g] == SSST_TYPE_PRESSURE)
                begin
                    data_nxt = i_pressure;
                end
                else if (cfg.type_sel[g] == SSST_TYPE_TEMP)
                begin
                    data_nxt = i_temperature;
                end
            end
        end

        always_ff @(posedge i_mclk)
        begin
            if (!i_reset_n)
            begin
                data_r <= 16'h0000;
            end
            else
            begin
                data_r <= data_nxt;
            end
        end

        assign o_slot_data[g] = data_r;

        property p_pattern_forced;
            @(posedge i_mclk) disable iff (!i_reset_n)
            (grp == SSST_ST_GRP_PATTERN) |=> (data_r == ssst_pattern($past(cfg.st_code[1:0])));
        endproperty
        a_pattern_forced: assert property (p_pattern_forced)
            else $error("fixed pattern not shown in slot");

        property p_dst_result;
            @(posedge i_mclk) disable iff (!i_reset_n)
            (grp == SSST_ST_GRP_DST && i_dst_valid) |=> (data_r == $past(i_dst_result));
        endproperty
        a_dst_result: assert property (p_dst_result)
            else $error("self-test result not loaded into slot");

        property p_normal_pressure;
            @(posedge i_mclk) disable iff (!i_reset_n)
            ((cfg.st_code == SSST_ST_NORMAL || cfg.st_code == SSST_ST_CM_VERIFY)
             && cfg.path_en && i_sample_stb && cfg.type_sel[g] == SSST_TYPE_PRESSURE)
            |=> (data_r == $past(i_pressure));
        endproperty
        a_normal_pressure: assert property (p_normal_pressure)
            else $error("pressure sample not loaded in normal mode");

        property p_temp_select;
            @(posedge i_mclk) disable iff (!i_reset_n)
            (cfg.st_code == SSST_ST_NORMAL && cfg.path_en && i_sample_stb
             && cfg.type_sel[g] == SSST_TYPE_TEMP) |=> (data_r == $past(i_temperature));
        endproperty
        a_temp_select: assert property (p_temp_select)
            else $error("temperature sample not loaded for temperature type");
    end

endmodule : ssst_slot_path

// >>> verilog/ssst_top.sv
// output-select, interrupt-pin mode and self-test register bank of the pressure sensor
// Summary of operation
// - The first slot type field picks pressure (01) or temperature (11) for the first slot.
// - The second slot type field picks pressure (01) or temperature (11) for the second slot.
// - Bit 2 at 43h selects active-high open drain with pull-down (0) or active-low with pull-up (1).
// - Registers 42h, 43h and 44h feed the register-array check signature.
// - The four self-test select bits are kept out of that signature.
// - Self-test codes 0000 and 0001 leave the slots carrying normal sensor data.
// - Codes 0100 to 0111 block dsp updates and show 0000h, AAAAh, 5555h, FFFFh.
// - Codes 1100 to 1111 run digital self-tests 0 to 3 and load their result into the slots.
// - A write to 42h restarts the dsp path and data is marked invalid until it is ready.
`timescale 1ns/10ps
module ssst_top
    import ssst_pkg::*;
(
    input wire logic i_mclk,
    input wire logic i_reset_n,
    input wire logic [7:0] i_reg_addr,
    input wire logic [7:0] i_reg_wdata,
    input wire logic i_reg_wr,
    input wire logic i_reg_rd,
    output logic [7:0] o_reg_rdata,
    input wire logic i_sample_stb,
    input wire logic [15:0] i_pressure,
    input wire logic [15:0] i_temperature,
    input wire logic i_dst_valid,
    input wire logic [15:0] i_dst_result,
    input wire logic i_dsp_init_done,
    input wire logic i_int_event,
    output logic [15:0] o_first_slot_data,
    output logic [15:0] o_second_slot_data,
    output logic [1:0] o_first_slot_type_sel,
    output logic [1:0] o_second_slot_type_sel,
    output logic [3:0] o_selftest_select,
    output logic o_cm_verify_en,
    output logic o_dsp_inhibit,
    output logic o_dst_run,
    output logic [1:0] o_dst_index,
    output logic o_dsp_restart,
    output logic o_data_valid,
    output logic [7:0] o_array_sig,
    output logic o_int_pin_o,
    output logic o_int_pin_oe,
    output logic o_int_pull_up_en,
    output logic o_int_pull_down_en
);

    // ==========================================================
    // register file
    logic [7:0] slot_type_r;
    logic [7:0] slot_type_nxt;
    logic [7:0] int_cfg_r;
    logic [7:0] int_cfg_nxt;
    logic [7:0] st_r;
    logic [7:0] st_nxt;
    logic [7:0] rdata_r;
    logic [7:0] rdata_nxt;
    logic [7:0] sig_r;
    logic [7:0] sig_nxt;
    logic restart_r;
    logic restart_nxt;
    ssst_state_t state_r;
    ssst_state_t state_nxt;
    logic wr_slot_type;

    assign wr_slot_type = i_reg_wr && (i_reg_addr == SSST_ADDR_SLOT_TYPE);

    always_comb
    begin
        slot_type_nxt = slot_type_r;
        int_cfg_nxt = int_cfg_r;
        st_nxt = st_r;
        rdata_nxt = rdata_r;
        if (i_reg_wr)
        begin
            case (i_reg_addr)
                SSST_ADDR_SLOT_TYPE: slot_type_nxt = i_reg_wdata;
                SSST_ADDR_INT_PIN: int_cfg_nxt = i_reg_wdata;
                SSST_ADDR_SELFTEST: st_nxt = i_reg_wdata;
                default: ;
            endcase
        end
        if (i_reg_rd)
        begin
            case (i_reg_addr)
                SSST_ADDR_SLOT_TYPE: rdata_nxt = slot_type_r;
                SSST_ADDR_INT_PIN: rdata_nxt = int_cfg_r;
                SSST_ADDR_SELFTEST: rdata_nxt = st_r;
                default: rdata_nxt = SSST_RDATA_UNMAPPED;
            endcase
        end
        // select bits excluded so self-test changes never trip the check
        sig_nxt = slot_type_r ^ int_cfg_r ^ {4'h0, st_r[3:0]};
    end

    // ==========================================================
    // dsp restart sequencing
    always_comb
    begin
        restart_nxt = wr_slot_type;
        state_nxt = state_r;
        case (state_r)
            SSST_RUN:
            begin
                if (wr_slot_type)
                begin
                    state_nxt = SSST_INIT;
                end
            end
            SSST_INIT:
            begin
                // a rewrite during init starts the wait over
                if (i_dsp_init_done && !wr_slot_type)
                begin
                    state_nxt = SSST_RUN;
                end
            end
            default: state_nxt = SSST_INIT;
        endcase
    end

    always_ff @(posedge i_mclk)
    begin
        if (!i_reset_n)
        begin
            slot_type_r <= SSST_RST_SLOT_TYPE;
            int_cfg_r <= SSST_RST_INT_PIN;
            st_r <= SSST_RST_SELFTEST;
            rdata_r <= 8'h00;
            sig_r <= 8'h00;
            restart_r <= 1'b0;
            state_r <= SSST_RUN;
        end
        else
        begin
            slot_type_r <= slot_type_nxt;
            int_cfg_r <= int_cfg_nxt;
            st_r <= st_nxt;
            rdata_r <= rdata_nxt;
            sig_r <= sig_nxt;
            restart_r <= restart_nxt;
            state_r <= state_nxt;
        end
    end

    // ==========================================================
    // interrupt pin driver
    logic int_mode;
    logic int_oe_r;
    logic int_oe_nxt;
    logic int_o_r;
    logic int_o_nxt;

    assign int_mode = int_cfg_r[SSST_INT_MODE_BIT];

    always_comb
    begin
        // open drain: only the active level is driven, the pull sets idle
        int_oe_nxt = i_int_event;
        int_o_nxt = int_mode ? 1'b0 : 1'b1;
    end

    always_ff @(posedge i_mclk)
    begin
        if (!i_reset_n)
        begin
            int_oe_r <= 1'b0;
            int_o_r <= 1'b1;
        end
        else
        begin
            int_oe_r <= int_oe_nxt;
            int_o_r <= int_o_nxt;
        end
    end

    // ==========================================================
    // outputs and sensor-data path
    ssst_cfg_if cfg_if ();
    logic [1:0][15:0] slot_data;

    assign cfg_if.type_sel[0] = slot_type_r[SSST_FIRST_TYPE_LSB +: 2];
    assign cfg_if.type_sel[1] = slot_type_r[SSST_SECOND_TYPE_LSB +: 2];
    assign cfg_if.st_code = st_r[SSST_ST_LSB +: 4];
    assign cfg_if.path_en = (state_r == SSST_RUN);

    ssst_slot_path u_slot_path (
        .i_mclk(i_mclk),
        .i_reset_n(i_reset_n),
        .cfg(cfg_if.path),
        .i_sample_stb(i_sample_stb),
        .i_pressure(i_pressure),
        .i_temperature(i_temperature),
        .i_dst_valid(i_dst_valid),
        .i_dst_result(i_dst_result),
        .o_slot_data(slot_data)
    );

    assign o_reg_rdata = rdata_r;
    assign o_first_slot_data = slot_data[0];
    assign o_second_slot_data = slot_data[1];
    assign o_first_slot_type_sel = cfg_if.type_sel[0];
    assign o_second_slot_type_sel = cfg_if.type_sel[1];
    assign o_selftest_select = cfg_if.st_code;
    assign o_cm_verify_en = (cfg_if.st_code == SSST_ST_CM_VERIFY);
    assign o_dsp_inhibit = (cfg_if.st_code[3:2] == SSST_ST_GRP_PATTERN);
    assign o_dst_run = (cfg_if.st_code[3:2] == SSST_ST_GRP_DST);
    assign o_dst_index = cfg_if.st_code[1:0];
    assign o_dsp_restart = restart_r;
    assign o_data_valid = cfg_if.path_en;
    assign o_array_sig = sig_r;
    assign o_int_pin_o = int_o_r;
    assign o_int_pin_oe = int_oe_r;
    assign o_int_pull_up_en = int_mode;
    assign o_int_pull_down_en = !int_mode;

    // ==========================================================
    // checks
    property p_type_fields;
        @(posedge i_mclk) disable iff (!i_reset_n)
        wr_slot_type |=> (o_first_slot_type_sel == $past(i_reg_wdata[6:5]))
                         && (o_second_slot_type_sel == $past(i_reg_wdata[3:2]));
    endproperty
    a_type_fields: assert property (p_type_fields)
        else $error("slot type fields not taken from written byte");

    property p_int_mode;
        @(posedge i_mclk) disable iff (!i_reset_n)
        // level launched from the mode seen with the event, a mode write may land meanwhile
        i_int_event |=> (o_int_pin_oe && (o_int_pin_o == !$past(int_mode))
                         && (o_int_pull_up_en == int_mode) && (o_int_pull_down_en == !int_mode));
    endproperty
    a_int_mode: assert property (p_int_mode)
        else $error("interrupt pin level or pull does not match mode bit");

    property p_sig_covers;
        @(posedge i_mclk) disable iff (!i_reset_n)
        (i_reg_wr && i_reg_addr == SSST_ADDR_INT_PIN && !i_reg_rd) ##1 !i_reg_wr
        |=> (o_array_sig == (slot_type_r ^ $past(i_reg_wdata, 2) ^ {4'h0, st_r[3:0]}));
    endproperty
    a_sig_covers: assert property (p_sig_covers)
        else $error("array signature misses interrupt pin register");

    property p_sig_excludes_st;
        @(posedge i_mclk) disable iff (!i_reset_n)
        (i_reg_wr && i_reg_addr == SSST_ADDR_SELFTEST && i_reg_wdata[3:0] == st_r[3:0])
        |=> ##1 $stable(o_array_sig);
    endproperty
    a_sig_excludes_st: assert property (p_sig_excludes_st)
        else $error("self-test select bits leak into array signature");

    sequence s_restart_req;
        wr_slot_type;
    endsequence

    sequence s_restart_seen;
        o_dsp_restart && !o_data_valid;
    endsequence

    property p_restart;
        @(posedge i_mclk) disable iff (!i_reset_n)
        s_restart_req |=> s_restart_seen;
    endproperty
    a_restart: assert property (p_restart)
        else $error("slot type write did not restart dsp path");

    property p_init_hold;
        @(posedge i_mclk) disable iff (!i_reset_n)
        (!o_data_valid && !i_dsp_init_done) |=> !o_data_valid;
    endproperty
    a_init_hold: assert property (p_init_hold)
        else $error("data marked valid before dsp init done");

    property p_dst_run;
        @(posedge i_mclk) disable iff (!i_reset_n)
        (i_reg_wr && i_reg_addr == SSST_ADDR_SELFTEST && i_reg_wdata[7:6] == 2'h3)
        |=> (o_dst_run && o_dst_index == $past(i_reg_wdata[5:4]) && !o_dsp_inhibit);
    endproperty
    a_dst_run: assert property (p_dst_run)
        else $error("digital self-test not started by select code");

endmodule : ssst_top
